// file: port_p_cfg.svh
// constants for the six-bit port configuration block
// assumes 32-bit apb words, one register per aligned word
`ifndef PORT_P_CFG_SVH
`define PORT_P_CFG_SVH

`define PIN_COUNT          6
`define OFS_PIN_INPUT      12'h000
`define OFS_DIRECTION      12'h004
`define OFS_REDUCED_DRIVE  12'h008
`define OFS_PULL_ENABLE    12'h00c
`define OFS_POLARITY       12'h010
`define OFS_OUTPUT_DATA    12'h014
`define OFS_EDGE_FLAGS     12'h018
`define OFS_EDGE_ENABLES   12'h01c
`define CFG_RESET          6'h00
`define PIN_LEVEL_IRQ      5
`define PIN_NMI            1
`define PIN_PWM1           1
`define PIN_PWM0           0
`define FIELD_WIDTH        6

`endif

// file: port_p_pkg.sv
// types for the six-bit port configuration block
// assumes port_p_cfg.svh is compiled alongside
package port_p_pkg;
    typedef logic [5:0] pin_vec_t;
    typedef enum logic [1:0] {
        drive_full      = 2'b00,
        drive_tenth     = 2'b01,
        drive_fifth     = 2'b10
    } drive_level_t;
endpackage

// file: port_p_pin_config.sv
// apb register block: direction, drive, pull, polarity, pin edge irq
// assumes pins synchronous-capable sampling on clk_sys at 10 mhz
//
// Our own choices: the placing of the registers and register access over APB.
`include "port_p_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module port_p_pin_config
    import port_p_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // apb slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pin levels from the pads
    input  wire logic [5:0]  pin_in,
    // overrides from other functions
    input  wire logic        level_irq_enable,
    input  wire logic        nmi_mask_bit,
    input  wire logic [1:0]  pwm_enable,
    input  wire logic [1:0]  pwm_out,
    // pad controls and interrupt
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe,
    output logic      [5:0]  pull_enable_out,
    output logic      [5:0]  pull_down_sel,
    output logic      [5:0]  drive_reduced,
    output logic             irq
);

    // configuration and data registers
    pin_vec_t port_direction;
    pin_vec_t port_reduced_drive;
    pin_vec_t port_pull_enable;
    pin_vec_t port_polarity_select;
    pin_vec_t port_output_data;
    pin_vec_t pin_edge_flags;
    pin_vec_t pin_edge_enables;
    // synchronizer stages and edge history
    pin_vec_t sync_a;
    pin_vec_t sync_b;
    pin_vec_t sync_prev;
    // sticky record of the first nmi mask clear
    logic     nmi_latched;

    // bus decode
    wire access_ph   = psel & penable;
    wire wr_en       = access_ph & pwrite;
    wire hit_pin     = paddr == `OFS_PIN_INPUT;
    wire hit_dir     = paddr == `OFS_DIRECTION;
    wire hit_rdr     = paddr == `OFS_REDUCED_DRIVE;
    wire hit_pull    = paddr == `OFS_PULL_ENABLE;
    wire hit_pol     = paddr == `OFS_POLARITY;
    wire hit_data    = paddr == `OFS_OUTPUT_DATA;
    wire hit_flag    = paddr == `OFS_EDGE_FLAGS;
    wire hit_ien     = paddr == `OFS_EDGE_ENABLES;
    wire hit_any     = hit_pin | hit_dir | hit_rdr | hit_pull | hit_pol
                     | hit_data | hit_flag | hit_ien;
    wire pin_vec_t wdata = pwdata[5:0];

    // per-register write strobes
    wire wr_dir      = wr_en & hit_dir;
    wire wr_rdr      = wr_en & hit_rdr;
    wire wr_pull     = wr_en & hit_pull;
    wire wr_pol      = wr_en & hit_pol;
    wire wr_data     = wr_en & hit_data;
    wire wr_ien      = wr_en & hit_ien;
    wire wr_flag     = wr_en & hit_flag;

    // effective direction with overrides
    pin_vec_t force_in;
    pin_vec_t force_out;
    pin_vec_t eff_dir;
    // per-pin driven value, data view and edge
    pin_vec_t drv_val;
    pin_vec_t data_view;
    pin_vec_t edge_hit;
    assign force_in[`PIN_LEVEL_IRQ] = level_irq_enable;
    assign force_in[`PIN_NMI]       = nmi_latched;
    assign force_in[4:2]            = 3'h0;
    assign force_in[0]              = 1'b0;
    assign force_out = {4'h0, pwm_enable};
    assign eff_dir = (port_direction | force_out) & ~force_in;

    // read mux
    wire pin_vec_t rd_field =
        hit_pin  ? sync_b :
        hit_dir  ? port_direction :
        hit_rdr  ? port_reduced_drive :
        hit_pull ? port_pull_enable :
        hit_pol  ? port_polarity_select :
        hit_data ? data_view :
        hit_flag ? pin_edge_flags :
        hit_ien  ? pin_edge_enables : 6'h00;

    // bus answer values ahead of their flops
    wire        next_pready  = psel & ~penable;
    wire        next_pslverr = psel & ~penable & ~hit_any;
    wire [31:0] next_prdata  = {26'h0, rd_field};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            nmi_latched <= 1'b0;
        else if (!nmi_mask_bit)
            nmi_latched <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            port_direction <= `CFG_RESET;
        else if (wr_dir)
            port_direction <= wdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            port_reduced_drive <= `CFG_RESET;
        else if (wr_rdr)
            port_reduced_drive <= wdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            port_pull_enable <= `CFG_RESET;
        else if (wr_pull)
            port_pull_enable <= wdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            port_polarity_select <= `CFG_RESET;
        else if (wr_pol)
            port_polarity_select <= wdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            port_output_data <= `CFG_RESET;
        else if (wr_data)
            port_output_data <= wdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            pin_edge_enables <= `CFG_RESET;
        else if (wr_ien)
            pin_edge_enables <= wdata;
    end

    // ready answers in the access cycle, no waits
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            pready <= 1'b0;
        else
            pready <= next_pready;
    end

    // error flag stands with ready, unmapped only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            pslverr <= 1'b0;
        else
            pslverr <= next_pslverr;
    end

    // read data taken from the decoded register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else
            prdata <= next_prdata;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(pin_edge_flags & pin_edge_enables);
    end

    // per-pin logic: one copy for each port pin
    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
        // synchronized level and the one before it
        wire now_level  = sync_b[i];
        wire last_level = sync_prev[i];
        // polarity bit: pull-down and rising sense when set
        wire pol_high   = port_polarity_select[i];
        // effective direction of this pin, one = output
        wire is_output  = eff_dir[i];
        // the two edge kinds on the synchronized level
        wire rise_seen  = now_level & ~last_level;
        wire fall_seen  = ~now_level & last_level;
        // write-one-to-clear strobe for this flag
        wire flag_clear = wr_flag & wdata[i];
        // pad control values ahead of their flops
        wire next_pull  = port_pull_enable[i] & ~is_output;
        wire next_drive = port_reduced_drive[i] & is_output;

        assign edge_hit[i] = pol_high ? rise_seen : fall_seen;

        // stored bit if its direction register bit is set, else pin level
        assign data_view[i] = port_direction[i] ? port_output_data[i]
                                                : now_level;

        // pwm value wins on pins that carry a channel
        if (i < 2) begin : g_pwm
            assign drv_val[i] = pwm_enable[i] ? pwm_out[i]
                                              : port_output_data[i];
        end else begin : g_gpio
            assign drv_val[i] = port_output_data[i];
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                sync_a[i]    <= 1'b0;
                sync_b[i]    <= 1'b0;
                sync_prev[i] <= 1'b0;
            end else begin
                sync_a[i]    <= pin_in[i];
                sync_b[i]    <= sync_a[i];
                sync_prev[i] <= sync_b[i];
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                pin_edge_flags[i] <= 1'b0;
            else if (edge_hit[i])
                pin_edge_flags[i] <= 1'b1;
            else if (flag_clear)
                pin_edge_flags[i] <= 1'b0;
        end

        // driven value for the pad
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                pin_out[i] <= 1'b0;
            else
                pin_out[i] <= drv_val[i];
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                pin_oe[i] <= 1'b0;
            else
                pin_oe[i] <= is_output;
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                pull_enable_out[i] <= 1'b0;
            else
                pull_enable_out[i] <= next_pull;
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                pull_down_sel[i] <= 1'b0;
            else
                pull_down_sel[i] <= pol_high;
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n)
                drive_reduced[i] <= 1'b0;
            else
                drive_reduced[i] <= next_drive;
        end
    end

endmodule

`default_nettype wire

// file: port_p_pin_config_props.sv
// checker for the port block: pad control and apb answer
// assumes it is bound onto port_p_pin_config
`timescale 1ns/1ps
`default_nettype none
module port_p_props (
    input wire logic       clk_sys, arst_n, psel, penable, pready, pslverr,
    input wire logic       level_irq_enable, nmi_mask_bit,
    input wire logic [1:0] pwm_enable, pwm_out,
    input wire logic [5:0] pin_out, pin_oe, pull_enable_out, drive_reduced
);
    logic [1:0] nmi_seen;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // cleared nmi mask, aged two cycles
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n) nmi_seen <= 2'b00;
        else nmi_seen <= {nmi_seen[0], nmi_seen[0] | ~nmi_mask_bit};
    chk_setup_answered:
        assert property (psel && !penable |=> pready) else $error("no answer");
    chk_reset_idle:
        assert property ($rose(arst_n) |-> pin_oe == 6'h00) else $error("oe");
    chk_level_input:
        assert property (level_irq_enable[*2] |=> !pin_oe[5]) else $error("p5");
    chk_nmi_sticky:
        assert property (nmi_seen[1] |=> !pin_oe[1]) else $error("p1 input");
    chk_pwm_output:
        assert property (pwm_enable[0][*2] |=> pin_oe[0]) else $error("p0 oe");
    chk_pwm_value:
        assert property ((pwm_enable[0] && $stable(pwm_out))[*3]
            |-> pin_out[0] == pwm_out[0]) else $error("p0 value");
    chk_pull_input:
        assert property ((pull_enable_out & pin_oe) == 6'h00) else $error("pull");
    chk_drive_output:
        assert property ((drive_reduced & ~pin_oe) == 6'h00) else $error("drv");
    // main scenarios seen
    cover property (pready && pslverr);
    cover property (nmi_seen[1] && pwm_enable[1]);
    cover property (level_irq_enable && pin_oe[4]);
endmodule
bind port_p_pin_config port_p_props props (.*);
`default_nettype wire

// file: port_p_pins.sv
// pad model: driven level, pull device, or level set by the bench
// assumes the bench picks free levels and short faults
`timescale 1ns/1ps
`default_nettype none
module port_p_pins (
    input  wire logic [5:0] pin_out, pin_oe, pull_enable_out,
    input  wire logic [5:0] pull_down_sel, ext_level, short_low,
    output logic      [5:0] pin_in
);
    assign pin_in = ~short_low & (pin_oe & pin_out
        | ~pin_oe & pull_enable_out & ~pull_down_sel
        | ~pin_oe & ~pull_enable_out & ext_level);
endmodule
`default_nettype wire

// file: port_p_pin_config_bench.sv
// self-checking bench for the port configuration block
// assumes the pad model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module port_p_pin_config_bench;
    logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        level_irq_enable = 0, nmi_mask_bit = 1, pready, pslverr, irq, er;
    logic [1:0]  pwm_enable = 0, pwm_out = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [5:0]  pin_in, pin_out, pin_oe, pull_enable_out, pull_down_sel;
    logic [5:0]  drive_reduced, ext_level = 0, short_low = 0;
    int          err_count = 0, check_count = 0, cyc = 0;
    port_p_pin_config dut (.*);
    port_p_pins pads (.*);
    // clock and hang guard
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc > 2000) begin
        err_count++;
        end_sim;
    end
    task wt(input int n); repeat (n) @(posedge clk_sys); endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, rd, e);
    endtask
    task t_regs;
        for (int a = 4; a <= 16; a += 4) begin
            rdc("reset", a[11:0], 0);
            wr(a[11:0], 32'hffff_ffff);
            rdc("width", a[11:0], 32'h3f);
            wr(a[11:0], 0);
        end
        wr(12'h000, 32'h3f);
        rdc("ro input", 12'h000, 0);
        rdc("unmapped", 12'h020, 0);
        chk("slverr", er, 1);
        $display("regs done");
    endtask
    task t_dir;
        ext_level <= 6'h2a;
        wt(4);
        rdc("pins", 12'h000, 32'h2a);
        wr(12'h014, 32'h15);
        wr(12'h004, 32'h3f);
        short_low <= 6'h01;
        wt(4);
        chk("oe", pin_oe, 6'h3f);
        rdc("short seen", 12'h000, 32'h14);
        rdc("data", 12'h014, 32'h15);
        short_low <= 0;
        level_irq_enable <= 1;
        wt(3);
        chk("lvl input", pin_oe, 6'h1f);
        rdc("dir kept", 12'h004, 32'h3f);
        level_irq_enable <= 0;
        $display("dir done");
    endtask
    task t_over;
        wr(12'h004, 0);
        pwm_enable <= 2'b11; pwm_out <= 2'b10;
        wt(3);
        chk("pwm oe", pin_oe, 6'h03);
        chk("pwm out", pin_out[1:0], 2'b10);
        nmi_mask_bit <= 0;
        wt(1);
        nmi_mask_bit <= 1;
        wt(3);
        chk("nmi input", pin_oe, 6'h01);
        pwm_enable <= 0;
        wr(12'h004, 32'h3f);
        wr(12'h008, 32'h07);
        wt(3);
        chk("drive", drive_reduced, 6'h05);
        wr(12'h004, 32'h30);
        wr(12'h00c, 32'h3f);
        wr(12'h010, 32'h0f);
        wt(3);
        chk("drive off", drive_reduced, 0);
        chk("pull on", pull_enable_out, 6'h0f);
        chk("pull dir", pull_down_sel, 6'h0f);
        wr(12'h004, 0);
        wt(4);
        rdc("pulled", 12'h000, 32'h30);
        $display("over done");
    endtask
    task t_irq;
        wr(12'h00c, 0);
        wr(12'h010, 32'h01);
        ext_level <= 0;
        wt(4);
        wr(12'h018, 32'h3f);
        wr(12'h01c, 32'h01);
        ext_level <= 6'h03;
        wt(6);
        chk("irq", irq, 1);
        rdc("rise flag", 12'h018, 32'h01);
        wr(12'h01c, 0);
        ext_level <= 6'h01;
        wt(6);
        chk("masked", irq, 0);
        rdc("fall flag", 12'h018, 32'h03);
        wr(12'h018, 32'h03);
        rdc("cleared", 12'h018, 0);
        $display("irq done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        wt(4);
        arst_n <= 1;
        t_regs;
        t_dir;
        t_over;
        t_irq;
        end_sim;
    end
endmodule
`default_nettype wire
